// >>> tb/ir_carrier_generator_tb.sv
// Register level tests of the carrier generator.
`timescale 1ns/100ps
`include "irc_map.svh"
module ir_carrier_generator_tb;
  logic clk, rst_b, awv, wv, bready, arv, rready, pd, gout, goe, bv, rv, awr, wr_r, arr, pin, oe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [15:0] hi_len, lo_len;
  int error_cnt = 0;
  int checks = 0;
  irc_top i_dut (.clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .power_down_i(pd), .gpio_out_i(gout),
    .gpio_oe_i(goe), .carrier_output_pin_o(pin), .carrier_output_pin_oe_o(oe));
  irc_emitter_model i_emit (.clk_i(clk), .rst_b_i(rst_b), .pin_i(pin), .oe_i(oe),
    .high_len_o(hi_len), .low_len_o(lo_len));
  task automatic test_done();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h want %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv && bready) begin
        chk(bresp, er);
        bready <= 1'b0;
        n = 99;
      end
    end
    if (n < 99) chk(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
      if (rv && rready) begin
        chk(rdata, ed);
        chk(rresp, er);
        rready <= 1'b0;
        n = 99;
      end
    end
    if (n < 99) chk(32'h0, 32'h1);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Span covers about four times the expected run of some 1200 cycles.
  initial begin
    #125000;
    error_cnt++;
    test_done();
  end
  initial begin
    {rst_b, awv, wv, bready, arv, rready, pd, gout, goe} = 9'h0;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(`IRC_ADDR_MODE, 32'h0, `IRC_RESP_OKAY);
    rd(`IRC_ADDR_COUNT, 32'h0, `IRC_RESP_OKAY);
    rd(`IRC_ADDR_RELOAD, 32'h0, `IRC_RESP_OKAY);
    rd(`IRC_ADDR_DUTY, 32'h0, `IRC_RESP_OKAY);
    rd(12'h004, 32'h0, `IRC_RESP_SLVERR);
    wr(12'h004, 32'h3, `IRC_RESP_SLVERR);
    rd(`IRC_ADDR_MODE, 32'h0, `IRC_RESP_OKAY);
    gout <= 1'b1;
    goe <= 1'b1;
    tick(1);
    chk({oe, pin}, 32'h3);
    wr(`IRC_ADDR_COUNT, 32'h10, `IRC_RESP_OKAY);
    tick(20);
    rd(`IRC_ADDR_COUNT, 32'h10, `IRC_RESP_OKAY);
    wstrb <= 4'he;
    wr(`IRC_ADDR_COUNT, 32'h55, `IRC_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`IRC_ADDR_COUNT, 32'h10, `IRC_RESP_OKAY);
    {gout, goe} <= 2'h0;
    wr(`IRC_ADDR_MODE, 32'h1, `IRC_RESP_OKAY);
    tick(2);
    chk({oe, pin}, 32'h0);
    wr(`IRC_ADDR_MODE, 32'h2, `IRC_RESP_OKAY);
    tick(2);
    chk({oe, pin}, 32'h2);
    wr(`IRC_ADDR_COUNT, 32'h97, `IRC_RESP_OKAY);
    wr(`IRC_ADDR_RELOAD, 32'h97, `IRC_RESP_OKAY);
    wr(`IRC_ADDR_DUTY, 32'hba, `IRC_RESP_OKAY);
    wr(`IRC_ADDR_MODE, 32'h3, `IRC_RESP_OKAY);
    tick(400);
    chk(hi_len, 32'd35);
    chk(lo_len, 32'd70);
    wr(`IRC_ADDR_RELOAD, 32'ha0, `IRC_RESP_OKAY);
    rd(`IRC_ADDR_RELOAD, 32'h0, `IRC_RESP_OKAY);
    tick(400);
    chk(hi_len, 32'd26);
    chk(lo_len, 32'd70);
    @(posedge clk);
    pd <= 1'b1;
    tick(300);
    chk({oe, pin}, 32'h2);
    @(posedge clk);
    pd <= 1'b0;
    wr(`IRC_ADDR_MODE, 32'h0, `IRC_RESP_OKAY);
    gout <= 1'b1;
    tick(2);
    chk({oe, pin}, 32'h1);
    test_done();
  end
endmodule // ir_carrier_generator_tb
bind irc_top irc_top_monitor i_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .power_down_i(power_down_i), .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i),
  .carrier_output_pin_o(carrier_output_pin_o),
  .carrier_output_pin_oe_o(carrier_output_pin_oe_o));

// >>> tb/irc_emitter_model.sv
// Emitter driver model that measures high and low run lengths on the pin.
`timescale 1ns/100ps
module irc_emitter_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  input wire logic oe_i,
  output logic [15:0] high_len_o,
  output logic [15:0] low_len_o
);
  logic last;
  logic [15:0] run;
  // An undriven pin is taken as dark, as the emitter input is pulled down.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last <= 1'b0;
      run <= 16'h0;
      high_len_o <= 16'h0;
      low_len_o <= 16'h0;
    end else if ((pin_i && oe_i) == last) begin
      run <= run + 16'h1;
    end else begin
      if (last) high_len_o <= run;
      else low_len_o <= run;
      last <= pin_i && oe_i;
      run <= 16'h1;
    end
  end
endmodule // irc_emitter_model

// >>> tb/irc_top_monitor.sv
// Concurrent checks on the ports of the carrier generator top.
`timescale 1ns/100ps
module irc_top_monitor (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic power_down_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  input wire logic carrier_output_pin_o,
  input wire logic carrier_output_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_write_resp_time: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer not on time");
  a_bresp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write answer dropped early");
  a_read_resp_time: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer not on time");
  a_rdata_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read answer dropped early");
  a_write_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
  a_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  a_power_down_low: assert property (power_down_i && carrier_output_pin_oe_o && !gpio_oe_i
    |-> !carrier_output_pin_o) else $error("pin not low in power-down");
  a_gpio_pass: assert property (!carrier_output_pin_oe_o |-> !gpio_oe_i
    && carrier_output_pin_o == gpio_out_i) else $error("port control not passed");
endmodule // irc_top_monitor

// >>> verilog/irc_counter.sv
// Carrier counter with reload on overflow and duty compare phase.
`timescale 1ns/100ps
`include "irc_map.svh"
module irc_counter
  import irc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic count_wr_i,
  input wire irc_byte_t count_wdata_i,
  input wire irc_byte_t reload_hold_i,
  input wire irc_byte_t duty_i,
  output irc_byte_t count_o,
  output logic carrier_o,
  output logic overflow_o
);

  irc_byte_t count;
  irc_byte_t next_count;
  logic high;
  logic next_high;
  logic run_q;
  logic overflow;

  always_comb begin
    // RL10 overflow detect.
    overflow = run_i && (count == `IRC_COUNT_MAX);
    next_count = count;
    next_high = high;
    // RL15 software preset count.
    if (count_wr_i) begin
      next_count = count_wdata_i;
    // RL11 automatic reload.
    end else if (overflow) begin
      next_count = reload_hold_i;
    // RL5 count up.
    end else if (run_i) begin
      next_count = count + `IRC_COUNT_STEP;
    end
    if (!run_i) begin
      next_high = 1'b0;
    // RL17 high after reload.
    end else if (!run_q || overflow) begin
      next_high = 1'b1;
    end
    // RL9 duty compare low.
    if (run_i && (next_count == duty_i)) begin
      next_high = 1'b0;
    end
  end

  // RL6 system clock only.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= `IRC_RST_COUNT;
      high <= 1'b0;
      run_q <= 1'b0;
    end else begin
      count <= next_count;
      high <= next_high;
      run_q <= run_i;
    end
  end

  assign count_o = count;
  assign carrier_o = high;
  assign overflow_o = overflow;

endmodule // irc_counter

// >>> verilog/irc_map.svh
// Register offsets, field positions, reset values and counts of the carrier generator.
`ifndef IRC_MAP_SVH
`define IRC_MAP_SVH

`define IRC_IDX_RELOAD 10'h0cd
`define IRC_IDX_MODE 10'h0da
`define IRC_IDX_COUNT 10'h0db
`define IRC_IDX_DUTY 10'h0e8

`define IRC_ADDR_RELOAD {`IRC_IDX_RELOAD, 2'h0}
`define IRC_ADDR_MODE {`IRC_IDX_MODE, 2'h0}
`define IRC_ADDR_COUNT {`IRC_IDX_COUNT, 2'h0}
`define IRC_ADDR_DUTY {`IRC_IDX_DUTY, 2'h0}

`define IRC_BIT_OUTPUT_ENABLE 0
`define IRC_BIT_PIN_SELECT 1

`define IRC_RST_RELOAD 8'h00
`define IRC_RST_MODE 2'h0
`define IRC_RST_COUNT 8'h00
`define IRC_RST_DUTY 8'h00

`define IRC_COUNT_MAX 8'hff
`define IRC_COUNT_STEP 8'h01

`define IRC_RESP_OKAY 2'h0
`define IRC_RESP_SLVERR 2'h2

`endif

// >>> verilog/irc_pin_mux.sv
// Output pin selection between port control, forced low and carrier.
`timescale 1ns/100ps
module irc_pin_mux
  import irc_pkg::*;
(
  input wire irc_pin_mode_t mode_i,
  input wire logic power_down_i,
  input wire logic carrier_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  output logic pin_o,
  output logic pin_oe_o
);

  always_comb begin
    pin_o = 1'b0;
    pin_oe_o = 1'b1;
    case (mode_i)
      // RL1 port keeps pin.
      IRC_PIN_GPIO: begin
        pin_o = gpio_out_i;
        pin_oe_o = gpio_oe_i;
      end
      // RL3 carrier emitted.
      IRC_PIN_CARRIER: begin
        // RL4 low in power-down.
        pin_o = carrier_i && !power_down_i;
      end
      // RL2 forced low.
      default: begin
        pin_o = 1'b0;
      end
    endcase
  end

endmodule // irc_pin_mux

// >>> verilog/irc_pkg.sv
// Types shared by the carrier generator modules.
package irc_pkg;

  typedef logic [7:0] irc_byte_t;

  typedef enum logic [1:0] {
    IRC_PIN_GPIO,
    IRC_PIN_LOW,
    IRC_PIN_CARRIER
  } irc_pin_mode_t;

endpackage

// >>> verilog/irc_top.sv
// Infrared carrier generator with its AXI4-Lite register slave.
// How it works
// RL1: Pin-select clear leaves the pin under ordinary port control.
// RL2: Pin-select set with output enable clear drives the pin low.
// RL3: Carrier appears only with pin-select and output enable both set.
// RL4: In power-down the pin is held low whatever the counter does; the code does this only in carrier mode, not under port control.
// RL5: The timer is an 8-bit counter stepping by one each tick.
// RL6: The counter ticks on the system clock only, without prescaler.
// RL7: The timer raises no interrupt; its only effect is the pin.
// RL8: Once enabled, counting proceeds upward from the reload value.
// RL9: Count equal to duty value switches the output from high to low.
// RL10: Wrapping from 0xff to 0x00 ends the low phase.
// RL11: On overflow the reload value loads and the next cycle starts.
// RL12: Reload writes go to a buffer used only at the next overflow.
// RL13: High lasts duty minus reload ticks, low lasts 256 minus duty.
// RL14: Software derives reload as 256 minus period times clock rate.
// RL15: Software presets the count to the reload value before enabling.
// RL16: Software sets count, reload, duty, pin-select, then output enable.
// RL17: After each reload the output is high until the duty match.
`timescale 1ns/100ps
`include "irc_map.svh"
module irc_top
  import irc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic power_down_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  output logic carrier_output_pin_o,
  output logic carrier_output_pin_oe_o
);

  // Write channel state.
  logic aw_held;
  logic next_aw_held;
  logic [11:0] aw_addr;
  logic [11:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic do_write;
  logic wr_mapped;
  logic wr_low_lane;

  // Read channel state.
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;

  // Register file state.
  logic [1:0] mode;
  logic [1:0] next_mode;
  irc_byte_t reload_hold;
  irc_byte_t next_reload_hold;
  irc_byte_t duty;
  irc_byte_t next_duty;
  logic count_wr;
  irc_byte_t count_value;
  logic wr_reload;
  logic wr_mode;
  logic wr_count;
  logic wr_duty;

  // Carrier path.
  irc_pin_mode_t pin_mode;
  logic carrier_run;
  logic carrier_level;

  function automatic logic addr_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == `IRC_ADDR_RELOAD) begin
      hit = 1'b1;
    end else if (addr == `IRC_ADDR_MODE) begin
      hit = 1'b1;
    end else if (addr == `IRC_ADDR_COUNT) begin
      hit = 1'b1;
    end else if (addr == `IRC_ADDR_DUTY) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Both handshakes are refused while a response waits, so a second write
  // cannot overrun the first one before the master has seen its answer.
  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_mapped = addr_mapped(aw_addr);
  assign wr_low_lane = w_strb[0];

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_mapped ? `IRC_RESP_OKAY : `IRC_RESP_SLVERR;
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
      next_bresp = `IRC_RESP_OKAY;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `IRC_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;

  // Reads are answered one cycle after the address is taken.
  assign s_axi_arready_o = !rvalid;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = `IRC_RESP_OKAY;
      if (s_axi_araddr_i == `IRC_ADDR_MODE) begin
        next_rdata = {30'h0000_0000, mode};
      end else if (s_axi_araddr_i == `IRC_ADDR_COUNT) begin
        next_rdata = {24'h00_0000, count_value};
      end else if (s_axi_araddr_i == `IRC_ADDR_RELOAD) begin
        // Write-only registers read back as zero.
        next_rdata = 32'h0000_0000;
      end else if (s_axi_araddr_i == `IRC_ADDR_DUTY) begin
        next_rdata = 32'h0000_0000;
      end else begin
        next_rresp = `IRC_RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
      next_rdata = 32'h0000_0000;
      next_rresp = `IRC_RESP_OKAY;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `IRC_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  // Only the low byte lane carries register data; other lanes are ignored.
  // One strobe per register, so the register updates below stay independent
  // of the address comparison and cannot pick up a stale address.
  always_comb begin
    wr_reload = 1'b0;
    wr_mode = 1'b0;
    wr_count = 1'b0;
    wr_duty = 1'b0;
    if (aw_addr == `IRC_ADDR_RELOAD) begin
      wr_reload = do_write && wr_low_lane;
    end else if (aw_addr == `IRC_ADDR_MODE) begin
      wr_mode = do_write && wr_low_lane;
    end else if (aw_addr == `IRC_ADDR_COUNT) begin
      wr_count = do_write && wr_low_lane;
    end else if (aw_addr == `IRC_ADDR_DUTY) begin
      wr_duty = do_write && wr_low_lane;
    end
  end

  always_comb begin
    next_mode = mode;
    next_reload_hold = reload_hold;
    next_duty = duty;
    count_wr = wr_count;
    if (wr_mode) begin
      next_mode = w_data[1:0];
    end
    // RL12 buffered reload write.
    if (wr_reload) begin
      next_reload_hold = w_data[7:0];
    end
    if (wr_duty) begin
      next_duty = w_data[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode <= `IRC_RST_MODE;
      reload_hold <= `IRC_RST_RELOAD;
      duty <= `IRC_RST_DUTY;
    end else begin
      mode <= next_mode;
      reload_hold <= next_reload_hold;
      duty <= next_duty;
    end
  end

  always_comb begin
    // RL1 port control.
    if (!mode[`IRC_BIT_PIN_SELECT]) begin
      pin_mode = IRC_PIN_GPIO;
    // RL3 both bits set.
    end else if (mode[`IRC_BIT_OUTPUT_ENABLE]) begin
      pin_mode = IRC_PIN_CARRIER;
    // RL2 enable clear.
    end else begin
      pin_mode = IRC_PIN_LOW;
    end
  end

  // RL8 count from reload.
  // The counter stops with the oscillator in power-down and restarts from
  // wherever it stood, so software may preset it again after wake-up.
  assign carrier_run = mode[`IRC_BIT_OUTPUT_ENABLE] && !power_down_i;

  // RL13 phase lengths.
  // RL7 no interrupt source.
  irc_counter u_counter (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(carrier_run),
    .count_wr_i(count_wr),
    .count_wdata_i(w_data[7:0]),
    .reload_hold_i(reload_hold),
    .duty_i(duty),
    .count_o(count_value),
    .carrier_o(carrier_level),
    .overflow_o()
  );

  irc_pin_mux u_pin_mux (
    .mode_i(pin_mode),
    .power_down_i(power_down_i),
    .carrier_i(carrier_level),
    .gpio_out_i(gpio_out_i),
    .gpio_oe_i(gpio_oe_i),
    .pin_o(carrier_output_pin_o),
    .pin_oe_o(carrier_output_pin_oe_o)
  );

endmodule // irc_top
